// ---- verilog/dcs_draw_seq.sv ----
/*
  Draw command sequencer: turns draw requests written over APB into a
  stream of vertex element numbers with per-slot elements and the
  instance counter, fetching index words and indirect records itself.
  Assumes one memory read outstanding at a time and a fetch stage that
  takes vertices with a valid/ready handshake.
*/
// Chosen here: the register addresses and the APB interface to the registers.
// Notes on behaviour
// - sequential draw emits start..start+count-1 ascending
// - illegal primitive mode raises enum error
// - negative count raises value error, no output
// - disabled slot uses stored current value
// - enabled slot current value undefined after draw
// - negative start raises value error here
// - 32-bit instance counter, zero outside loops
// - repeat range per instance, counter cleared after
// - sequential record: count, total, start, reserved
// - nonzero reserved word never hangs the block
// - multi sequential: each pair non-instanced, counter zero
// - indexed draw fetches element index[i]
// - index type byte/halfword/word, else rejected
// - repeated indexed replays list per instance
// - multi indexed: each pair separate, counter zero
// - bounded draw: end below start is value error
// - out-of-range indices flagged, still emitted
// - large spans only slow, never fail
// - bias added unsigned 32-bit with wrap
// - range compare happens before bias
// - indexed record read; unbound index buffer errors
// - reset restores initial array state
// - restart index ends primitive, compared before bias
// - divisor zero per vertex, else per divisor instances; multi draws use the per-vertex element in every slot
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_draw_seq (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [31:0] rd_addr,
  input wire logic rd_rvalid,
  input wire logic [31:0] rd_rdata,
  output logic vtx_valid,
  input wire logic vtx_ready,
  output logic vtx_restart,
  output logic [31:0] vtx_elem,
  output logic [`DCS_SLOT_N*32-1:0] vtx_slot_elem,
  output logic [31:0] instance_counter,
  output logic [`DCS_SLOT_N-1:0] vtx_use_current,
  output logic draw_busy
);
  // Index size as a shift: byte 0, halfword 1, word 2
  function automatic logic [4:0] idx_shift(input logic [1:0] t);
    idx_shift = {3'b000, t};
  endfunction
  // Pick the index value out of a fetched word
  function automatic logic [31:0] idx_pick(input logic [31:0] w, input logic [1:0] lane,
                                           input logic [1:0] t);
    logic [31:0] s;
    s = w >> {lane, 3'b000};
    unique case (t)
      2'h0: idx_pick = {24'h000000, s[7:0]};
      2'h1: idx_pick = {16'h0000, s[15:0]};
      default: idx_pick = w;
    endcase
  endfunction
  dcs_pkg::dcs_state_rec_t r_q;  // Registered state
  dcs_pkg::dcs_state_rec_t r_d;  // Next state

  // Outputs come straight from the state flops
  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign rd_valid = r_q.rd_valid;
  assign rd_addr = r_q.rd_addr;
  assign vtx_valid = r_q.vtx_valid;
  assign vtx_restart = r_q.vtx_restart;
  assign vtx_elem = r_q.vtx_elem;
  assign vtx_slot_elem = r_q.vslot;
  assign instance_counter = r_q.inst;
  assign vtx_use_current = r_q.use_cur;
  assign draw_busy = r_q.busy;

  logic setup;      // APB setup phase seen
  logic wr;         // APB write taking effect
  logic indexed;    // Current draw reads an index list
  logic multi;      // Current draw walks the pair list
  logic rep;        // Current draw repeats instances
  logic [31:0] rdv; // Read mux result
  logic hit;        // Address decodes
  logic [31:0] idx; // Fetched index value
  logic [31:0] iaddr; // Byte address of next index

  // Next-state logic for bus, launch and sequencing
  always_comb
  begin
    r_d = r_q;
    idx = idx_pick(rd_rdata, r_q.lane, r_q.itype);
    iaddr = r_q.ibuf + r_q.w_off + (r_q.pos << idx_shift(r_q.itype));
    indexed = (r_q.kind >= dcs_pkg::K_IDX);
    multi = (r_q.kind == dcs_pkg::K_SEQ_MULTI) || (r_q.kind == dcs_pkg::K_IDX_MULTI);
    rep = (r_q.kind == dcs_pkg::K_SEQ_REP) || (r_q.kind == dcs_pkg::K_IDX_REP);
    setup = psel && !penable && !r_q.pready;
    wr = psel && penable && r_q.pready && pwrite && !r_q.pslverr;
    // Read decode; unmapped words answer with an error; past the list and slot ranges they read aliased words, elsewhere zero
    hit = 1'b1;
    rdv = 32'h0000_0000;
    if (paddr >= `DCS_SLOT)
    begin
      hit = (paddr < `DCS_SLOT + 8'h40) && (paddr[3:2] != 2'h3);
      unique case (paddr[3:2])
        2'h0: rdv = r_q.scfg[paddr[5:4]];
        2'h1: rdv = r_q.sbase[paddr[5:4]];
        2'h2: rdv = r_q.sdiv[paddr[5:4]];
        default: rdv = 32'h0000_0000;
      endcase
    end
    else if (paddr >= `DCS_LIST)
    begin
      hit = (paddr < `DCS_LIST + 8'h20);
      rdv = r_q.list[paddr[4:2]];
    end
    else
    begin
      unique case (paddr[7:2])
        6'(`DCS_CMD >> 2): rdv = {17'h0, r_q.list_n, r_q.ibuf_bound, r_q.restart_en,
                                  r_q.itype, r_q.mode, r_q.kind};
        6'(`DCS_STATUS >> 2): rdv = {20'h0, r_q.stale, 3'b000, r_q.range_viol, r_q.err_op,
                                     r_q.err_value, r_q.err_enum, draw_busy};
        6'(`DCS_FIRST >> 2): rdv = r_q.first;
        6'(`DCS_COUNT >> 2): rdv = r_q.count;
        6'(`DCS_TOTAL >> 2): rdv = r_q.total;
        6'(`DCS_OFFSET >> 2): rdv = r_q.offset;
        6'(`DCS_BIAS >> 2): rdv = r_q.bias;
        6'(`DCS_RLO >> 2): rdv = r_q.rlo;
        6'(`DCS_RHI >> 2): rdv = r_q.rhi;
        6'(`DCS_RESTART >> 2): rdv = r_q.restart;
        6'(`DCS_IBUF >> 2): rdv = r_q.ibuf;
        6'(`DCS_IND >> 2): rdv = r_q.ind;
        6'(`DCS_INST >> 2): rdv = r_q.inst;
        default: hit = 1'b0;
      endcase
    end
    // APB answers one cycle after setup
    r_d.pready = setup;
    if (setup)
    begin
      r_d.prdata = pwrite ? 32'h0000_0000 : rdv;
      r_d.pslverr = !hit;
    end
    // Disabled slots take the stored current value
    for (int s = 0; s < `DCS_SLOT_N; s++)
      r_d.use_cur[s] = !r_q.scfg[s][`DCS_CFG_EN];
    // Error flags clear by writing one; later sets in this cycle win
    if (wr && paddr == `DCS_STATUS)
    begin
      r_d.err_enum = r_q.err_enum & !pwdata[`DCS_ST_ENUM];
      r_d.err_value = r_q.err_value & !pwdata[`DCS_ST_VALUE];
      r_d.err_op = r_q.err_op & !pwdata[`DCS_ST_OP];
      r_d.range_viol = r_q.range_viol & !pwdata[`DCS_ST_RANGE];
      r_d.stale = r_q.stale & ~pwdata[`DCS_ST_STALE +: `DCS_SLOT_N];
    end
    // Parameter writes are dropped while a draw runs
    else if (wr && r_q.st == dcs_pkg::S_IDLE)
    begin
      if (paddr >= `DCS_SLOT)
      begin
        unique case (paddr[3:2])
          2'h0: r_d.scfg[paddr[5:4]] = pwdata;
          2'h1: r_d.sbase[paddr[5:4]] = pwdata;
          default: r_d.sdiv[paddr[5:4]] = pwdata;
        endcase
      end
      else if (paddr >= `DCS_LIST)
        r_d.list[paddr[4:2]] = pwdata;
      else
      begin
        unique case (paddr)
          `DCS_FIRST: r_d.first = pwdata;
          `DCS_COUNT: r_d.count = pwdata;
          `DCS_TOTAL: r_d.total = pwdata;
          `DCS_OFFSET: r_d.offset = pwdata;
          `DCS_BIAS: r_d.bias = pwdata;
          `DCS_RLO: r_d.rlo = pwdata;
          `DCS_RHI: r_d.rhi = pwdata;
          `DCS_RESTART: r_d.restart = pwdata;
          `DCS_IBUF: r_d.ibuf = pwdata;
          `DCS_IND: r_d.ind = pwdata;
          default:
          begin
          end
        endcase
        // Writing the command word launches a draw
        if (paddr == `DCS_CMD)
        begin
          r_d.kind = pwdata[3:0];
          r_d.mode = pwdata[7:4];
          r_d.itype = pwdata[9:8];
          r_d.restart_en = pwdata[10];
          r_d.ibuf_bound = pwdata[11];
          r_d.list_n = pwdata[14:12];
          r_d.w_first = r_q.first;
          r_d.w_count = r_q.count;
          r_d.w_total = r_q.total;
          r_d.w_off = r_q.offset;
          r_d.w_bias = r_q.bias;
          r_d.word_n = 3'h0;
          r_d.st = dcs_pkg::S_CHECK;
          if (pwdata[3:0] == dcs_pkg::K_IDX_MEM && !pwdata[11])
          begin
            r_d.err_op = 1'b1;
            r_d.st = dcs_pkg::S_IDLE;
          end
          else if (pwdata[3:0] == dcs_pkg::K_SEQ_MEM || pwdata[3:0] == dcs_pkg::K_IDX_MEM)
          begin
            r_d.fetch_cmd = 1'b1;
            r_d.rd_valid = 1'b1;
            r_d.rd_addr = r_q.ind;
            r_d.st = dcs_pkg::S_MREQ;
          end
        end
      end
    end
    unique case (r_q.st)
      dcs_pkg::S_IDLE:
      begin
      end
      // Hold the read request until the memory takes it
      dcs_pkg::S_MREQ:
        if (rd_ready)
        begin
          r_d.rd_valid = 1'b0;
          r_d.st = dcs_pkg::S_MWAIT;
        end
      dcs_pkg::S_MWAIT:
        if (rd_rvalid && r_q.fetch_cmd)
        begin
          // Record words: count, total, start or first index, bias, reserved
          unique case (r_q.word_n)
            3'h0: r_d.w_count = rd_rdata;
            3'h1: r_d.w_total = rd_rdata;
            3'h2:
              if (indexed)
                r_d.w_off = rd_rdata << idx_shift(r_q.itype);
              else
                r_d.w_first = rd_rdata;
            3'h3:
              if (indexed)
                r_d.w_bias = rd_rdata;
            default:
            begin
            end
          endcase
          r_d.word_n = r_q.word_n + 3'h1;
          // Reserved word is read and dropped; its value cannot stall us
          if (r_q.word_n == (indexed ? `DCS_IDX_WORDS : `DCS_SEQ_WORDS))
          begin
            r_d.fetch_cmd = 1'b0;
            r_d.st = dcs_pkg::S_CHECK;
          end
          else
          begin
            r_d.rd_valid = 1'b1;
            r_d.rd_addr = r_q.ind + {27'h0, r_q.word_n + 3'h1, 2'b00};
            r_d.st = dcs_pkg::S_MREQ;
          end
        end
        else if (rd_rvalid)
        begin
          // Restart compare and range compare both before the bias
          r_d.vtx_valid = 1'b1;
          r_d.vtx_restart = r_q.restart_en && (idx == r_q.restart);
          r_d.vtx_elem = idx + r_q.w_bias;
          if (r_q.kind == dcs_pkg::K_IDX_BOUNDED && !r_d.vtx_restart &&
              (idx < r_q.rlo || idx > r_q.rhi))
            r_d.range_viol = 1'b1;
          for (int s = 0; s < `DCS_SLOT_N; s++)
            r_d.vslot[s] = (r_q.sdiv[s] == 32'h0 || multi) ? r_d.vtx_elem : r_q.ielem[s];
          r_d.st = dcs_pkg::S_EMIT;
        end
      // Argument checks; any failure drops the draw with no output
      dcs_pkg::S_CHECK:
      begin
        r_d.st = dcs_pkg::S_STEP;
        if (r_q.kind > dcs_pkg::K_IDX_MEM || r_q.mode >= `DCS_MODE_LIMIT)
        begin
          r_d.err_enum = 1'b1;
          r_d.st = dcs_pkg::S_IDLE;
        end
        else if (indexed && r_q.itype == `DCS_ITYPE_BAD)
        begin
          r_d.err_enum = 1'b1;
          r_d.st = dcs_pkg::S_IDLE;
        end
        else if (r_q.fetch_cmd == 1'b0 &&
                 ((r_q.kind != dcs_pkg::K_SEQ_MEM && r_q.kind != dcs_pkg::K_IDX_MEM &&
                   !multi && r_q.w_count[31]) ||
                  (!indexed && !multi && r_q.kind != dcs_pkg::K_SEQ_MEM &&
                   r_q.w_first[31]) ||
                  (rep && r_q.w_total[31]) ||
                  (r_q.kind == dcs_pkg::K_IDX_BOUNDED && r_q.rhi < r_q.rlo)))
        begin
          r_d.err_value = 1'b1;
          r_d.st = dcs_pkg::S_IDLE;
        end
        for (int e = 0; e < `DCS_LIST_N; e++)
          if (multi && e < r_q.list_n && r_q.list[2*e + (indexed ? 0 : 1)][31])
          begin
            r_d.err_value = 1'b1;
            r_d.st = dcs_pkg::S_IDLE;
          end
        // Non-repeating kinds other than the record kinds run as one instance at counter zero
        if (!rep && r_q.kind != dcs_pkg::K_SEQ_MEM && r_q.kind != dcs_pkg::K_IDX_MEM)
          r_d.w_total = 32'h1;
        r_d.entry = 3'h0;
        r_d.pos = 32'h0;
        r_d.inst = 32'h0;
        for (int s = 0; s < `DCS_SLOT_N; s++)
        begin
          r_d.sub[s] = 32'h0;
          r_d.ielem[s] = 32'h0;
        end
        // First pair of a multi draw
        if (multi)
        begin
          r_d.w_first = r_q.list[0];
          r_d.w_count = indexed ? r_q.list[0] : r_q.list[1];
          r_d.w_off = r_q.list[1];
          if (r_q.list_n == 3'h0)
            r_d.w_total = 32'h0;
        end
      end
      dcs_pkg::S_STEP:
        // Counts are full width, so long ranges just take longer
        if (r_q.pos == r_q.w_count || r_q.w_total == 32'h0)
        begin
          r_d.pos = 32'h0;
          if (r_q.inst + 32'h1 < r_q.w_total)
          begin
            r_d.inst = r_q.inst + 32'h1;
            for (int s = 0; s < `DCS_SLOT_N; s++)
              if (r_q.sdiv[s] != 32'h0)
              begin
                r_d.sub[s] = r_q.sub[s] + 32'h1;
                if (r_d.sub[s] == r_q.sdiv[s])
                begin
                  r_d.sub[s] = 32'h0;
                  r_d.ielem[s] = r_q.ielem[s] + 32'h1;
                end
              end
          end
          else if (multi && {29'h0, r_q.entry} + 32'h1 < {29'h0, r_q.list_n})
          begin
            r_d.entry = r_q.entry + 3'h1;
            r_d.w_first = r_q.list[2*r_d.entry];
            r_d.w_count = indexed ? r_q.list[2*r_d.entry] : r_q.list[2*r_d.entry + 1];
            r_d.w_off = r_q.list[2*r_d.entry + 1];
          end
          else
          begin
            // Draw over: counter back to zero, fetched slots lose their value
            r_d.inst = 32'h0;
            for (int s = 0; s < `DCS_SLOT_N; s++)
              if (r_q.scfg[s][`DCS_CFG_EN] && r_q.w_total != 32'h0)
                r_d.stale[s] = 1'b1;
            r_d.st = dcs_pkg::S_IDLE;
          end
        end
        else if (indexed)
        begin
          // Word-aligned fetch; the lane picks the index inside it
          r_d.rd_valid = 1'b1;
          r_d.rd_addr = {iaddr[31:2], 2'b00};
          r_d.lane = iaddr[1:0];
          r_d.st = dcs_pkg::S_MREQ;
        end
        else
        begin
          r_d.vtx_valid = 1'b1;
          r_d.vtx_restart = 1'b0;
          r_d.vtx_elem = r_q.w_first + r_q.pos;
          for (int s = 0; s < `DCS_SLOT_N; s++)
            r_d.vslot[s] = (r_q.sdiv[s] == 32'h0 || multi) ? r_d.vtx_elem : r_q.ielem[s];
          r_d.st = dcs_pkg::S_EMIT;
        end
      // Hold the vertex until the fetch stage takes it
      dcs_pkg::S_EMIT:
        if (vtx_ready)
        begin
          r_d.vtx_valid = 1'b0;
          r_d.pos = r_q.pos + 32'h1;
          r_d.st = dcs_pkg::S_STEP;
        end
      default: r_d.st = dcs_pkg::S_IDLE;
    endcase
    r_d.busy = (r_d.st != dcs_pkg::S_IDLE);  // Busy flag registered with the state
  end

  // State register; reset brings back the initial array state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_q <= '0;
      r_q.st <= dcs_pkg::S_IDLE;
      r_q.use_cur <= '1;
      for (int s = 0; s < `DCS_SLOT_N; s++)
        r_q.scfg[s] <= `DCS_CFG_RST;
    end
    else
      r_q <= r_d;
  end
endmodule

// ---- verilog/dcs_regs.svh ----
/*
  Register map, field positions and reset values of the draw sequencer.
  Assumes APB byte addresses with 32-bit aligned words.
*/
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
// Register byte offsets
`define DCS_CMD 8'h00
`define DCS_STATUS 8'h04
`define DCS_FIRST 8'h08
`define DCS_COUNT 8'h0c
`define DCS_TOTAL 8'h10
`define DCS_OFFSET 8'h14
`define DCS_BIAS 8'h18
`define DCS_RLO 8'h1c
`define DCS_RHI 8'h20
`define DCS_RESTART 8'h24
`define DCS_IBUF 8'h28
`define DCS_IND 8'h2c
`define DCS_INST 8'h30
`define DCS_LIST 8'h40
`define DCS_SLOT 8'h80
// Sizes
`define DCS_SLOT_N 4
`define DCS_LIST_N 4
`define DCS_MODE_LIMIT 4'hc
`define DCS_ITYPE_BAD 2'h3
`define DCS_SEQ_WORDS 3'h3
`define DCS_IDX_WORDS 3'h4
// Slot config fields and reset: four components, float type, all flags clear
`define DCS_CFG_EN 0
`define DCS_CFG_RST 32'h0000_0020
// Status fields
`define DCS_ST_BUSY 0
`define DCS_ST_ENUM 1
`define DCS_ST_VALUE 2
`define DCS_ST_OP 3
`define DCS_ST_RANGE 4
`define DCS_ST_STALE 8
`endif

// ---- verilog/dcs_pkg.sv ----
/*
  Types of the draw sequencer: draw kinds, states and the state record.
  Assumes dcs_regs.svh for sizes.
*/
`include "dcs_regs.svh"
package dcs_pkg;
  // Draw kinds as written in the command register
  typedef enum logic [3:0] {
    K_SEQ = 4'h0, K_SEQ_REP = 4'h1, K_SEQ_MEM = 4'h2, K_SEQ_MULTI = 4'h3,
    K_IDX = 4'h4, K_IDX_REP = 4'h5, K_IDX_MULTI = 4'h6, K_IDX_BOUNDED = 4'h7,
    K_IDX_MEM = 4'h8
  } dcs_kind_t;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_MREQ = 3'b001, S_MWAIT = 3'b010, S_CHECK = 3'b011,
    S_STEP = 3'b100, S_EMIT = 3'b101
  } dcs_state_t;
  // Whole state of the block
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [3:0] kind;
    logic [3:0] mode;
    logic [1:0] itype;
    logic restart_en;
    logic ibuf_bound;
    logic [2:0] list_n;
    logic err_enum;
    logic err_value;
    logic err_op;
    logic range_viol;
    logic [`DCS_SLOT_N-1:0] stale;
    logic [31:0] first, count, total, offset, bias, rlo, rhi, restart, ibuf, ind;
    logic [2*`DCS_LIST_N-1:0][31:0] list;
    logic [`DCS_SLOT_N-1:0][31:0] scfg, sbase, sdiv, sub, ielem, vslot;
    dcs_state_t st;
    logic fetch_cmd;
    logic [2:0] word_n;
    logic [2:0] entry;
    logic [1:0] lane;
    logic [31:0] pos, inst, w_first, w_count, w_total, w_off, w_bias;
    logic rd_valid;
    logic [31:0] rd_addr;
    logic vtx_valid;
    logic vtx_restart;
    logic [31:0] vtx_elem;
    logic [`DCS_SLOT_N-1:0] use_cur;
    logic busy;
  } dcs_state_rec_t;
endpackage

// ---- verif/dcs_seq_checker_assertions.sv ----
/*
  Port checker for the draw sequencer.
  Assumes it is bound onto dcs_draw_seq; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module dcs_seq_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [31:0] rd_addr,
  input wire logic vtx_valid,
  input wire logic vtx_ready,
  input wire logic [31:0] vtx_elem,
  input wire logic [31:0] instance_counter,
  input wire logic draw_busy
);
  // Single domain, so one clocking and one disable
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Answer one cycle after setup, never held
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  // Unmapped slot word refused
  unmapped_err_a: assert property (pready && paddr[7] && paddr[3:2] == 2'h3 |-> pslverr)
    else $error("unmapped slot word not refused");
  // Counter is zero whenever no draw runs
  inst_idle_zero_a: assert property (!draw_busy |-> instance_counter == 32'h0)
    else $error("instance counter nonzero while idle");
  // Vertices only inside a draw
  vtx_in_draw_a: assert property (vtx_valid |-> draw_busy)
    else $error("vertex outside a draw");
  // Offered vertex held until taken
  vtx_hold_a: assert property (vtx_valid && !vtx_ready |=> vtx_valid && $stable(vtx_elem))
    else $error("vertex dropped or changed while stalled");
  // Read request held and aligned
  rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_addr))
    else $error("read request changed while stalled");
  rd_align_a: assert property (rd_valid |-> rd_addr[1:0] == 2'h0 && draw_busy)
    else $error("read address unaligned or outside draw");
  // Every draw ends in bounded time
  draw_ends_a: assert property ($rose(draw_busy) |-> ##[1:1000] !draw_busy)
    else $error("draw never finished");
  // Main scenarios reached
  cov_inst: cover property (vtx_valid && vtx_ready && instance_counter == 32'h2);
  cov_read: cover property (rd_valid && rd_ready);
  cov_err: cover property (pready && pslverr);
endmodule

// ---- verif/dcs_mem_model.sv ----
/*
  Far side of the sequencer: memory holding records and index words, and
  the vertex fetch stage. Assumes one read outstanding, addresses < 256.
*/
`timescale 1ns/1ps
module dcs_mem_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [31:0] rd_addr,
  output logic rd_rvalid,
  output logic [31:0] rd_rdata,
  output logic vtx_ready
);
  logic [31:0] mem [0:63]; // Filled by the bench
  logic [3:0] tick; // Drives the stall pattern
  initial
  begin
    for (int k = 0; k < 64; k++)
      mem[k] = 32'h0;
  end
  // Accept every other cycle, answer the cycle after; stale data inverted
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_ready <= 1'b0;
      rd_rvalid <= 1'b0;
      rd_rdata <= 32'h0;
      vtx_ready <= 1'b0;
      tick <= 4'h0;
    end
    else
    begin
      tick <= tick + 4'h1;
      vtx_ready <= (tick[1:0] != 2'h3); // Fetch stage stalls one cycle in four
      rd_rvalid <= 1'b0;
      rd_rdata <= ~rd_rdata;
      if (rd_valid && rd_ready)
      begin
        rd_ready <= 1'b0;
        rd_rvalid <= 1'b1;
        rd_rdata <= mem[rd_addr[7:2]];
      end
      else
        rd_ready <= rd_valid && tick[0];
    end
  end
endmodule

// ---- verif/dcs_draw_seq_tb.sv ----
/*
  Self-checking bench for the draw sequencer.
  Assumes dcs_mem_model as far side and the APB map of dcs_regs.svh.
*/
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_draw_seq_tb;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_addr, rd_rdata, vtx_elem, instance_counter;
  logic rd_valid, rd_ready, rd_rvalid, vtx_valid, vtx_ready, vtx_restart, draw_busy;
  logic [`DCS_SLOT_N*32-1:0] vtx_slot_elem;
  logic [3:0] vtx_use_current;
  logic [31:0] rdat, st; // Last read word, last status
  logic perr;
  logic [31:0] vq[$], iq[$]; // Taken vertices and their instance
  int miscompares, samples_checked;
  dcs_draw_seq i_dcs_draw_seq (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rd_rvalid(rd_rvalid), .rd_rdata(rd_rdata), .vtx_valid(vtx_valid),
    .vtx_ready(vtx_ready), .vtx_restart(vtx_restart), .vtx_elem(vtx_elem),
    .vtx_slot_elem(vtx_slot_elem), .instance_counter(instance_counter),
    .vtx_use_current(vtx_use_current), .draw_busy(draw_busy));
  dcs_mem_model i_dcs_mem_model (.sys_clk(sys_clk), .rst_b(rst_b), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_rvalid(rd_rvalid), .rd_rdata(rd_rdata),
    .vtx_ready(vtx_ready));
  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Log each vertex taken; restart tokens get a marker
  always @(posedge sys_clk)
    if (vtx_valid === 1'b1 && vtx_ready === 1'b1)
    begin
      vq.push_back(vtx_restart === 1'b1 ? 32'hffff_ffff : vtx_elem);
      iq.push_back(instance_counter);
    end
  task tally_and_finish;
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      miscompares++;
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16)
    begin
      $display("MISMATCH %0t apb answer missing", $time);
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Launch a draw and poll until idle
  task automatic run(input logic [31:0] cmd);
    int n;
    vq.delete();
    iq.delete();
    apb(1'b1, `DCS_CMD, cmd);
    for (n = 0; n < 200; n++)
    begin
      apb(1'b0, `DCS_STATUS, 32'h0);
      if (rdat[0] === 1'b0)
        break;
    end
    st = rdat;
    if (n == 200)
    begin
      $display("MISMATCH %0t draw hung", $time);
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic cmpq(input logic [31:0] e[$], input logic [31:0] ei[$]);
    chk(vq.size(), e.size(), "vertex total");
    foreach (e[k])
      if (k < vq.size())
      begin
        chk(vq[k], e[k], "element");
        chk(iq[k], ei[k], "instance");
      end
  endtask
  task t_reset;
    for (int s = 0; s < 4; s++)
      for (int f = 0; f < 3; f++)
      begin
        apb(1'b0, `DCS_SLOT + 8'(s * 16 + f * 4), 32'h0);
        chk(rdat, f == 0 ? `DCS_CFG_RST : 32'h0, "slot reset");
      end
    apb(1'b0, `DCS_RESTART, 32'h0);
    chk(rdat, 32'h0, "restart reset");
    apb(1'b0, `DCS_INST, 32'h0);
    chk(rdat, 32'h0, "instance reset");
    apb(1'b0, 8'h8c, 32'h0);
    chk({31'h0, perr}, 32'h1, "unmapped refused");
    $display("test reset done");
  endtask
  task t_seq;
    apb(1'b1, `DCS_SLOT, 32'h21); // Slot 0 enabled only
    apb(1'b1, `DCS_FIRST, 32'h5);
    apb(1'b1, `DCS_COUNT, 32'h3);
    run(32'h40);
    cmpq('{32'h5, 32'h6, 32'h7}, '{32'h0, 32'h0, 32'h0});
    chk({28'h0, vtx_use_current}, 32'he, "disabled slots current");
    chk({28'h0, st[11:8]}, 32'h1, "stale slot");
    apb(1'b1, `DCS_TOTAL, 32'h3);
    apb(1'b1, `DCS_FIRST, 32'h0);
    apb(1'b1, `DCS_COUNT, 32'h2);
    run(32'h41);
    cmpq('{0, 1, 0, 1, 0, 1}, '{0, 0, 1, 1, 2, 2});
    chk(instance_counter, 32'h0, "counter cleared");
    $display("test sequential done");
  endtask
  task t_multi;
    apb(1'b1, `DCS_LIST, 32'ha);
    apb(1'b1, `DCS_LIST + 8'h4, 32'h1);
    apb(1'b1, `DCS_LIST + 8'h8, 32'h14);
    apb(1'b1, `DCS_LIST + 8'hc, 32'h2);
    run(32'h2043);
    cmpq('{32'ha, 32'h14, 32'h15}, '{0, 0, 0});
    i_dcs_mem_model.mem[0] = 32'h2; // Record: count, total, first, reserved
    i_dcs_mem_model.mem[1] = 32'h2;
    i_dcs_mem_model.mem[2] = 32'h7;
    i_dcs_mem_model.mem[3] = 32'hdead; // Nonzero reserved word
    apb(1'b1, `DCS_IND, 32'h0);
    run(32'h42);
    cmpq('{7, 8, 7, 8}, '{0, 0, 1, 1});
    $display("test multi and record done");
  endtask
  task t_idx;
    i_dcs_mem_model.mem[16] = 32'h9;
    i_dcs_mem_model.mem[17] = 32'h55;
    i_dcs_mem_model.mem[18] = 32'h3;
    apb(1'b1, `DCS_IBUF, 32'h40);
    apb(1'b1, `DCS_OFFSET, 32'h0);
    apb(1'b1, `DCS_COUNT, 32'h3);
    apb(1'b1, `DCS_BIAS, 32'hffff_ffff);
    apb(1'b1, `DCS_RESTART, 32'h55);
    run(32'h644);
    cmpq('{32'h8, 32'hffff_ffff, 32'h2}, '{0, 0, 0});
    i_dcs_mem_model.mem[4] = 32'h2; // Record: count, total, first index, bias, reserved
    i_dcs_mem_model.mem[5] = 32'h1;
    i_dcs_mem_model.mem[6] = 32'h1;
    i_dcs_mem_model.mem[7] = 32'h4;
    apb(1'b1, `DCS_IND, 32'h10);
    run(32'ha48);
    cmpq('{32'h59, 32'h7}, '{0, 0});
    $display("test indexed done");
  endtask
  task t_err;
    logic [31:0] f[7] = '{0, 0, 0, 32'h8000_0000, 0, 0, 0};
    logic [31:0] c[7] = '{1, 1, 32'hffff_ffff, 1, 1, 1, 1};
    logic [31:0] h[7] = '{9, 9, 9, 9, 9, 9, 4};
    logic [31:0] m[7] = '{32'hc0, 32'h49, 32'h40, 32'h40, 32'h344, 32'h248, 32'h247};
    logic [31:0] x[7] = '{2, 2, 4, 4, 2, 8, 4};
    apb(1'b1, `DCS_RLO, 32'h5);
    for (int k = 0; k < 7; k++)
    begin
      apb(1'b1, `DCS_FIRST, f[k]);
      apb(1'b1, `DCS_COUNT, c[k]);
      apb(1'b1, `DCS_RHI, h[k]);
      run(m[k]);
      chk(st & 32'h1e, x[k], "error flag");
      chk(vq.size(), 32'h0, "no vertices on error");
      apb(1'b1, `DCS_STATUS, 32'hf1e);
    end
    $display("test errors done");
  endtask
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_seq;
    t_multi;
    t_idx;
    t_err;
    tally_and_finish();
  end
endmodule
bind dcs_draw_seq dcs_seq_checker i_dcs_seq_checker (.sys_clk(sys_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr), .vtx_valid(vtx_valid),
  .vtx_ready(vtx_ready), .vtx_elem(vtx_elem), .instance_counter(instance_counter),
  .draw_busy(draw_busy));
